// ==== hdl/vrc_top.sv ====
// Serial-slave control and status registers of a step-down regulator.
// Assumes an external pull-up on the data and indicator lines, and
// analog comparators delivering the status levels asynchronously.
// Bus data is caught by a flop on the serial clock itself.
`timescale 1ns/1ps
`include "vrc_cfg.svh"

// Behaviour
// - Voltage code applies only while arm bit set
// - Bits 6..0 are code, 10 mV steps
// - Slew field steps once per 2^N cycles
// - Mode bit one forces continuous PWM
// - Control bit zero set turns regulator off
// - Status bit 7 mirrors over-temperature shutdown
// - Status bit 4 flags overcurrent below third
// - Status bit 3 mirrors temperature warning
// - Status bit 0 shows output in window
// - Indicator released only inside 95..115 percent
// - Answer as serial slave at address 0x65
// - Shutdown pin ignores accesses, resets registers
module vrc_top (
	// Core clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       srst_in,
	// Serial bus; clock line doubles as link clock
	input  wire logic       scl_clk_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n_out,
	// Hardware enable pin
	input  wire logic       hw_enable_in,
	// Analog status levels
	input  wire logic       otp_trip_in,
	input  wire logic       overcurrent_protection_in,
	input  wire logic       vout_below_third_in,
	input  wire logic       temp_warn_in,
	input  wire logic       feedback_node_above_low_in,
	input  wire logic       feedback_node_below_high_in,
	// Regulator controls
	output logic            voltage_arm_bit_out,
	output logic      [6:0] voltage_code_scheme_out,
	output logic            force_pwm_out,
	output logic            regulator_run_out,
	// Regulation indicator pin, open drain
	output logic            regulation_indicator_pin_out,
	output logic            regulation_indicator_pin_oe_n_out
);
	import vrc_pkg::*;

	vrc_core_t              c_reg;
	vrc_core_t              c_next;
	vrc_link_t              l_reg;
	vrc_link_t              l_next;
	logic [`VRC_SYNC_W-1:0] raw;
	logic [`VRC_SYNC_W-1:0] syn;
	logic                   scl_s;
	logic                   sda_s;
	logic                   en_s;
	logic                   otp_s;
	logic                   ovc_trip_s;
	logic                   below_third_s;
	logic                   warn_s;
	logic                   fdbk_low_ok_s;
	logic                   fdbk_high_ok_s;
	logic                   in_window;
	logic                   start_cond;
	logic                   stop_cond;
	logic                   scl_fall;
	logic                   bit_ev;
	logic [7:0]             rx_byte;
	logic [7:0]             rd_data;

	// Link domain: sample data on each rising bus clock edge.
	// No reset here: the bus clock idles during reset, so a reset or a
	// toggle flop on it could not settle before the first frame.
	// The sample stands for a whole bus period; the core reads it only
	// after the synchronised clock rise has crossed.
	always_comb begin
		l_next         = l_reg;
		l_next.bit_val = sda_in;
	end

	always_ff @(posedge scl_clk_in) begin
		l_reg <= l_next;
	end

	// Core domain synchroniser bank, one bit per pin
	assign raw = {
		feedback_node_below_high_in,
		feedback_node_above_low_in,
		temp_warn_in,
		vout_below_third_in,
		overcurrent_protection_in,
		otp_trip_in,
		hw_enable_in,
		sda_in,
		scl_clk_in
	};

	vrc_sync2 #(
		.W (`VRC_SYNC_W)
	) u_core_sync (
		.clk_in  (core_clk_in),
		.srst_in (srst_in),
		.d_in    (raw),
		.q_out   (syn)
	);

	assign scl_s          = syn[0];
	assign sda_s          = syn[1];
	assign en_s           = syn[2];
	assign otp_s          = syn[3];
	assign ovc_trip_s     = syn[4];
	assign below_third_s  = syn[5];
	assign warn_s         = syn[6];
	assign fdbk_low_ok_s  = syn[7];
	assign fdbk_high_ok_s = syn[8];
	assign in_window      = fdbk_low_ok_s & fdbk_high_ok_s;

	// Bus events on the core clock
	assign start_cond = scl_s & c_reg.scl_prev & c_reg.sda_prev & ~sda_s;
	assign stop_cond  = scl_s & c_reg.scl_prev & ~c_reg.sda_prev & sda_s;
	assign scl_fall   = c_reg.scl_prev & ~scl_s;
	// One bit per bus clock rise; the link sample is settled by then
	assign bit_ev     = scl_s & ~c_reg.scl_prev;
	assign rx_byte    = {c_reg.shift[6:0], l_reg.bit_val};

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (c_reg.ptr)
			`VRC_OFS_VSEL: rd_data = c_reg.vsel;
			`VRC_OFS_CTRL: rd_data = c_reg.ctrl;
			`VRC_OFS_STAT: rd_data = c_reg.stat;
			default:       rd_data = `VRC_UNMAPPED_RD;
		endcase
	end

	always_comb begin
		c_next          = c_reg;
		c_next.scl_prev = scl_s;
		c_next.sda_prev = sda_s;
		c_next.sda_drv  = 1'b0;
		c_next.ind_drv  = 1'b0;

		// Live flags, never written by the bus
		// Levels only, no latching: a read shows the state now
		c_next.stat                     = `VRC_STAT_RST;
		c_next.stat[`VRC_STAT_OTP_BIT]  = otp_s;
		c_next.stat[`VRC_STAT_OVC_BIT]  = ovc_trip_s & below_third_s;
		c_next.stat[`VRC_STAT_WARN_BIT] = warn_s;
		c_next.stat[`VRC_STAT_WIN_BIT]  = in_window;
		c_next.ind_oe_n                 = in_window;
		c_next.pwm     = c_reg.ctrl[`VRC_CTRL_MODE_BIT];
		c_next.run     = en_s & ~c_reg.ctrl[`VRC_CTRL_DIS_BIT];

		// Enable first, so a shut-down part never takes a write
		if (!en_s) begin
			// Shutdown pin: bus deaf, registers back to defaults
			c_next.vsel     = `VRC_VSEL_RST;
			c_next.ctrl     = `VRC_CTRL_RST;
			c_next.state    = st_idle;
			c_next.cnt      = 4'h0;
			c_next.sda_oe_n = 1'b1;
		end else if (start_cond) begin
			c_next.state    = st_addr;
			c_next.cnt      = 4'h0;
			c_next.sda_oe_n = 1'b1;
		end else if (stop_cond) begin
			c_next.state    = st_idle;
			c_next.sda_oe_n = 1'b1;
		end else begin
			case (c_reg.state)
				st_addr, st_ptr, st_wdata: begin
					if (bit_ev) begin
						c_next.shift = rx_byte;
						c_next.cnt   = c_reg.cnt + 4'h1;
						if (c_reg.cnt == `VRC_CNT_LAST_BIT) begin
							if (c_reg.state == st_addr) begin
								if (rx_byte[7:1] == `VRC_SLAVE_ADDR) begin
									c_next.state = st_addr_ack;
									c_next.rw    = rx_byte[0];
								end else begin
									c_next.state = st_wait_stop;
								end
							end else if (c_reg.state == st_ptr) begin
								c_next.ptr   = rx_byte;
								c_next.state = st_ptr_ack;
							end else begin
								case (c_reg.ptr)
									`VRC_OFS_VSEL: c_next.vsel = rx_byte;
									`VRC_OFS_CTRL: c_next.ctrl = rx_byte;
									default: c_next.vsel = c_reg.vsel;
								endcase
								c_next.ptr   = c_reg.ptr + 8'h01;
								c_next.state = st_wdata_ack;
							end
						end
					end
				end
				// Pull low after the fall ending bit 8, free after the next
				st_addr_ack, st_ptr_ack, st_wdata_ack: begin
					if (bit_ev) begin
						c_next.cnt = `VRC_CNT_ACK_DONE;
					end
					if (scl_fall && c_reg.cnt == `VRC_CNT_ACK_SLOT) begin
						c_next.sda_oe_n = 1'b0;
					end
					if (scl_fall && c_reg.cnt == `VRC_CNT_ACK_DONE) begin
						c_next.cnt      = 4'h0;
						c_next.sda_oe_n = 1'b1;
						if (c_reg.state == st_addr_ack && c_reg.rw) begin
							c_next.shift    = rd_data;
							c_next.sda_oe_n = rd_data[7];
							c_next.state    = st_rdata;
						end else if (c_reg.state == st_addr_ack) begin
							c_next.state = st_ptr;
						end else begin
							c_next.state = st_wdata;
						end
					end
				end
				// Next bit goes out after each fall, stable by the rise
				st_rdata: begin
					if (bit_ev) begin
						c_next.cnt = c_reg.cnt + 4'h1;
					end
					if (scl_fall) begin
						if (c_reg.cnt == `VRC_CNT_ACK_SLOT) begin
							// Let the master drive its acknowledge
							c_next.sda_oe_n = 1'b1;
							c_next.state    = st_rdata_ack;
						end else begin
							c_next.shift    = {c_reg.shift[6:0], 1'b0};
							c_next.sda_oe_n = c_reg.shift[6];
						end
					end
				end
				// A master acknowledge asks for the next register
				st_rdata_ack: begin
					if (bit_ev) begin
						if (l_reg.bit_val) begin
							c_next.state = st_wait_stop;
						end else begin
							c_next.ptr = c_reg.ptr + 8'h01;
							c_next.cnt = `VRC_CNT_ACK_DONE;
						end
					end
					if (scl_fall && c_reg.cnt == `VRC_CNT_ACK_DONE) begin
						c_next.cnt      = 4'h0;
						c_next.shift    = rd_data;
						c_next.sda_oe_n = rd_data[7];
						c_next.state    = st_rdata;
					end
				end
				st_idle, st_wait_stop: begin
					c_next.sda_oe_n = 1'b1;
				end
				default: begin
					c_next.state    = st_idle;
					c_next.sda_oe_n = 1'b1;
				end
			endcase
		end

		if (srst_in) begin
			c_next          = '0;
			c_next.state    = st_idle;
			c_next.vsel     = `VRC_VSEL_RST;
			c_next.ctrl     = `VRC_CTRL_RST;
			c_next.sda_oe_n = 1'b1;
			c_next.ind_oe_n = 1'b0;
			// Edge history starts low; idle ignores the first rise
		end
	end

	// All core state in one struct, one flop bank
	always_ff @(posedge core_clk_in) begin
		c_reg <= c_next;
	end

	// Ramp only while armed; unarmed code is not applied
	// Ramp keeps its code through a hardware shutdown
	vrc_slew u_slew (
		.clk_in    (core_clk_in),
		.srst_in   (srst_in),
		.arm_in    (c_reg.vsel[`VRC_VSEL_ARM_BIT]),
		.target_in (c_reg.vsel[`VRC_VSEL_CODE_HI:`VRC_VSEL_CODE_LO]),
		.rate_in   (c_reg.ctrl[`VRC_CTRL_SLEW_HI:`VRC_CTRL_SLEW_LO]),
		.code_out  (voltage_code_scheme_out)
	);

	assign voltage_arm_bit_out               = c_reg.vsel[`VRC_VSEL_ARM_BIT];
	assign force_pwm_out                     = c_reg.pwm;
	assign regulator_run_out                 = c_reg.run;
	assign sda_out                           = c_reg.sda_drv;
	assign sda_oe_n_out                      = c_reg.sda_oe_n;
	assign regulation_indicator_pin_out      = c_reg.ind_drv;
	assign regulation_indicator_pin_oe_n_out = c_reg.ind_oe_n;

endmodule // vrc_top

// ==== include/vrc_cfg.svh ====
// Offsets, field positions and reset values of the regulator registers.
// Assumes inclusion by the top and slew modules and the bench.
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

// Serial slave address, seven bits
`define VRC_SLAVE_ADDR      7'h65

// Register offsets
`define VRC_OFS_VSEL        8'h01
`define VRC_OFS_CTRL        8'h02
`define VRC_OFS_STAT        8'h06

// Reset values
`define VRC_VSEL_RST        8'h00
`define VRC_CTRL_RST        8'h00
`define VRC_STAT_RST        8'h00
`define VRC_UNMAPPED_RD     8'h00

// Output voltage select fields
`define VRC_VSEL_ARM_BIT    7
`define VRC_VSEL_CODE_HI    6
`define VRC_VSEL_CODE_LO    0

// Common control fields
`define VRC_CTRL_SLEW_HI    6
`define VRC_CTRL_SLEW_LO    4
`define VRC_CTRL_MODE_BIT   1
`define VRC_CTRL_DIS_BIT    0

// Status fields
`define VRC_STAT_OTP_BIT    7
`define VRC_STAT_OVC_BIT    4
`define VRC_STAT_WARN_BIT   3
`define VRC_STAT_WIN_BIT    0

// Bit counts of one serial byte
`define VRC_CNT_LAST_BIT    4'h7
`define VRC_CNT_ACK_SLOT    4'h8
`define VRC_CNT_ACK_DONE    4'h9

// Width of the core-side synchroniser bank
`define VRC_SYNC_W          9

`endif

// ==== include/vrc_pkg.sv ====
// Types shared by the regulator register block.
// Assumes vrc_cfg.svh is on the include path.
package vrc_pkg;

	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_ptr,
		st_ptr_ack,
		st_wdata,
		st_wdata_ack,
		st_rdata,
		st_rdata_ack,
		st_wait_stop
	} vrc_state_t;

	typedef struct packed {
		vrc_state_t  state;
		logic [3:0]  cnt;
		logic [7:0]  shift;
		logic [7:0]  ptr;
		logic        rw;
		logic [7:0]  vsel;
		logic [7:0]  ctrl;
		logic [7:0]  stat;
		logic        sda_oe_n;
		logic        sda_drv;
		logic        ind_oe_n;
		logic        ind_drv;
		logic        run;
		logic        pwm;
		logic        scl_prev;
		logic        sda_prev;
	} vrc_core_t;

	typedef struct packed {
		logic        bit_val;
	} vrc_link_t;

	typedef struct packed {
		logic [6:0]  code;
		logic [6:0]  cnt;
	} vrc_slew_t;

endpackage

// ==== hdl/vrc_sync2.sv ====
// Two-stage synchroniser bank for levels entering a clock domain.
// Assumes inputs are levels that stay put for several clock periods.
`timescale 1ns/1ps
module vrc_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	// Levels
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} vrc_sync_t;

	vrc_sync_t r_reg;
	vrc_sync_t r_next;

	// First stage feeds only the second stage
	always_comb begin
		r_next        = r_reg;
		r_next.meta   = d_in;
		r_next.stable = r_reg.meta;
		if (srst_in) begin
			r_next = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		r_reg <= r_next;
	end

	assign q_out = r_reg.stable;

endmodule // vrc_sync2

// ==== hdl/vrc_slew.sv ====
// Output code ramp: one 10 mV step every 2^N core cycles toward target.
// Assumes the target and rate come from core-clock registers.
`timescale 1ns/1ps
`include "vrc_cfg.svh"
module vrc_slew (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	// Control
	input  wire logic       arm_in,
	input  wire logic [6:0] target_in,
	input  wire logic [2:0] rate_in,
	// Ramp output
	output logic      [6:0] code_out
);
	import vrc_pkg::*;

	vrc_slew_t  r_reg;
	vrc_slew_t  r_next;
	logic [7:0] span;
	logic [6:0] limit;

	always_comb begin
		span   = (8'h01 << rate_in) - 8'h01;
		limit  = span[6:0];
		r_next = r_reg;
		// Ramp holds while unarmed; no surprise moves
		if (!arm_in || r_reg.code == target_in) begin
			r_next.cnt = 7'h00;
		end else if (r_reg.cnt >= limit) begin
			r_next.cnt = 7'h00;
			if (r_reg.code < target_in) begin
				r_next.code = r_reg.code + 7'h01;
			end else begin
				r_next.code = r_reg.code - 7'h01;
			end
		end else begin
			r_next.cnt = r_reg.cnt + 7'h01;
		end
		if (srst_in) begin
			r_next = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		r_reg <= r_next;
	end

	assign code_out = r_reg.code;

endmodule // vrc_slew

// ==== test/vrc_top_monitor.sv ====
// Port checker for the regulator register block.
// Assumes it is bound to vrc_top and watches that module's ports only.
`timescale 1ns/1ps
module vrc_top_monitor (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       srst_in,
	// Pins
	input wire logic       sda_out,
	input wire logic       sda_oe_n_out,
	input wire logic       hw_enable_in,
	input wire logic       feedback_node_above_low_in,
	input wire logic       feedback_node_below_high_in,
	// Regulator side
	input wire logic       voltage_arm_bit_out,
	input wire logic [6:0] voltage_code_scheme_out,
	input wire logic       force_pwm_out,
	input wire logic       regulator_run_out,
	input wire logic       regulation_indicator_pin_out,
	input wire logic       regulation_indicator_pin_oe_n_out
);
	logic fdbk_ok;
	assign fdbk_ok = feedback_node_above_low_in & feedback_node_below_high_in;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (srst_in);

	a_open_drain: assert property (
		sda_out == 1'b0 && regulation_indicator_pin_out == 1'b0)
		else $error("open-drain pin driven high");
	a_ind_inside: assert property (
		fdbk_ok [*4] |=> regulation_indicator_pin_oe_n_out)
		else $error("indicator held low inside window");
	a_ind_outside: assert property (
		!fdbk_ok [*4] |=> !regulation_indicator_pin_oe_n_out)
		else $error("indicator released outside window");
	a_ind_cause: assert property (
		$rose(regulation_indicator_pin_oe_n_out) |->
		$past(fdbk_ok, 2) || $past(fdbk_ok, 3) || $past(fdbk_ok, 4))
		else $error("indicator released without cause");
	a_hw_off_regs: assert property (
		!hw_enable_in [*6] |=> !regulator_run_out &&
		!voltage_arm_bit_out && !force_pwm_out)
		else $error("controls alive in hardware shutdown");
	a_hw_off_bus: assert property (
		!hw_enable_in [*6] |=> sda_oe_n_out)
		else $error("data line driven in hardware shutdown");
	a_code_frozen: assert property (
		!voltage_arm_bit_out && $past(voltage_arm_bit_out) == 1'b0 |->
		$stable(voltage_code_scheme_out))
		else $error("code moved while unarmed");
	a_code_step: assert property (
		$changed(voltage_code_scheme_out) |->
		voltage_code_scheme_out - $past(voltage_code_scheme_out) == 7'h01 ||
		$past(voltage_code_scheme_out) - voltage_code_scheme_out == 7'h01)
		else $error("code jumped by more than one step");
endmodule // vrc_top_monitor

bind vrc_top vrc_top_monitor mon_u (.core_clk_in(core_clk_in),
	.srst_in(srst_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
	.hw_enable_in(hw_enable_in),
	.feedback_node_above_low_in(feedback_node_above_low_in),
	.feedback_node_below_high_in(feedback_node_below_high_in),
	.voltage_arm_bit_out(voltage_arm_bit_out),
	.voltage_code_scheme_out(voltage_code_scheme_out),
	.force_pwm_out(force_pwm_out), .regulator_run_out(regulator_run_out),
	.regulation_indicator_pin_out(regulation_indicator_pin_out),
	.regulation_indicator_pin_oe_n_out(regulation_indicator_pin_oe_n_out));

// ==== test/vrc_host_model.sv ====
// Serial bus master model, 20 ticks of 125 ns per bit.
// Assumes an external pull-up resolves the data line.
`timescale 1ns/1ps
module vrc_host_model (
	// Bit timing
	input  wire logic tick_in,
	// Bus lines
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_drv_out
);
	initial begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
	end
	task automatic hold(int n);
		repeat (n) @(posedge tick_in);
	endtask
	// Data moves only while the clock line is low
	task automatic bitx(logic b, output logic s);
		scl_out <= 1'b0;
		hold(2);
		sda_drv_out <= b;
		hold(8);
		scl_out <= 1'b1;
		hold(5);
		s = sda_in;
		hold(5);
	endtask
	task automatic start(logic rep);
		hold(1);
		if (rep) begin
			scl_out <= 1'b0;
			hold(2);
			sda_drv_out <= 1'b1;
			hold(8);
			scl_out <= 1'b1;
			hold(10);
		end
		sda_drv_out <= 1'b0;
		hold(10);
	endtask
	// Clock stays high after the frame ends
	task automatic stop();
		scl_out <= 1'b0;
		hold(2);
		sda_drv_out <= 1'b0;
		hold(8);
		scl_out <= 1'b1;
		hold(10);
		sda_drv_out <= 1'b1;
		hold(10);
	endtask
	task automatic wbyte(logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(d[i], s);
		bitx(1'b1, s);
		ack = ~s;
	endtask
	task automatic rbyte(logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(~mack, s);
	endtask
endmodule // vrc_host_model

// ==== test/vrc_top_bench.sv ====
// Self-checking bench for the regulator register block.
// Assumes vrc_cfg.svh on the include path and the host model.
`timescale 1ns/1ps
`include "vrc_cfg.svh"
module vrc_top_bench;
	logic       clk = 1'b0;
	logic       tick = 1'b0;
	logic       srst = 1'b1;
	logic       hw_en = 1'b1;
	logic [5:0] st = 6'h00;
	logic       scl, h_sda, sda_w, sda_o, sda_oe_n, arm, pwm, run;
	logic [6:0] code;
	int         error_cnt = 0;
	int         tests_run = 0;

	always #20 clk = ~clk;
	always #62.5 tick = ~tick;
	// Pull-up wins unless someone pulls low
	assign sda_w = h_sda & (sda_oe_n | sda_o);

	vrc_top dut_u (.core_clk_in(clk), .srst_in(srst), .scl_clk_in(scl),
		.sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
		.hw_enable_in(hw_en), .otp_trip_in(st[5]),
		.overcurrent_protection_in(st[4]), .vout_below_third_in(st[3]),
		.temp_warn_in(st[2]), .feedback_node_above_low_in(st[1]),
		.feedback_node_below_high_in(st[0]), .voltage_arm_bit_out(arm),
		.voltage_code_scheme_out(code), .force_pwm_out(pwm),
		.regulator_run_out(run), .regulation_indicator_pin_out(),
		.regulation_indicator_pin_oe_n_out());
	vrc_host_model h_u (.tick_in(tick), .sda_in(sda_w), .scl_out(scl),
		.sda_drv_out(h_sda));

	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic reg_wr(logic [7:0] o, logic [7:0] d, logic ea);
		logic a0, a1, a2;
		h_u.start(1'b0);
		h_u.wbyte({`VRC_SLAVE_ADDR, 1'b0}, a0);
		h_u.wbyte(o, a1);
		h_u.wbyte(d, a2);
		h_u.stop();
		chk("wr ack", {7'h0, ea}, {7'h0, a0 & a1 & a2});
	endtask
	task automatic reg_rd(logic [7:0] o, output logic [7:0] d);
		logic a0, a1, a2;
		h_u.start(1'b0);
		h_u.wbyte({`VRC_SLAVE_ADDR, 1'b0}, a0);
		h_u.wbyte(o, a1);
		h_u.start(1'b1);
		h_u.wbyte({`VRC_SLAVE_ADDR, 1'b1}, a2);
		h_u.rbyte(1'b0, d);
		h_u.stop();
		chk("rd ack", 8'h01, {7'h0, a0 & a1 & a2});
	endtask
	function automatic logic [7:0] stat_exp(logic [5:0] s);
		return {s[5], 2'b00, s[4] & s[3], s[2], 2'b00, s[1] & s[0]};
	endfunction
	task automatic final_report;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// About 50k cycles expected
	initial begin
		#(40 * 100000);
		error_cnt++;
		final_report();
	end

	initial begin
		logic [7:0] d, c;
		logic [6:0] c1;
		logic [1:0] r;
		logic       a;
		int         n;
		void'($urandom(32'h6507));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		reg_rd(`VRC_OFS_VSEL, d);
		chk("vsel rst", `VRC_VSEL_RST, d);
		reg_rd(`VRC_OFS_CTRL, d);
		chk("ctrl rst", `VRC_CTRL_RST, d);
		reg_rd(8'h03, d);
		chk("unmapped", `VRC_UNMAPPED_RD, d);
		h_u.start(1'b0);
		h_u.wbyte({7'h64, 1'b0}, a);
		h_u.stop();
		chk("foreign ack", 8'h00, {7'h0, a});
		for (int i = 0; i < 3; i++) begin
			c = (i == 0) ? 8'hff : 8'($urandom);
			@(posedge clk);
			st <= (i == 0) ? 6'h3f : 6'($urandom);
			reg_wr(`VRC_OFS_CTRL, c, 1'b1);
			reg_rd(`VRC_OFS_CTRL, d);
			chk("ctrl", c, d);
			chk("pwm run", {6'h0, c[1], ~c[0]}, {6'h0, pwm, run});
			reg_wr(`VRC_OFS_STAT, ~stat_exp(st), 1'b1);
			reg_rd(`VRC_OFS_STAT, d);
			chk("status", stat_exp(st), d);
		end
		reg_wr(`VRC_OFS_VSEL, 8'h55, 1'b1);
		repeat (20) @(posedge clk);
		chk("unarmed", 8'h00, {arm, code});
		reg_rd(`VRC_OFS_VSEL, d);
		chk("vsel", 8'h55, d);
		@(posedge clk);
		hw_en <= 1'b0;
		repeat (10) @(posedge clk);
		chk("hw off run", 8'h00, {7'h0, run});
		reg_wr(`VRC_OFS_CTRL, 8'h02, 1'b0);
		@(posedge clk);
		hw_en <= 1'b1;
		repeat (10) @(posedge clk);
		reg_rd(`VRC_OFS_VSEL, d);
		chk("vsel cleared", 8'h00, d);
		reg_rd(`VRC_OFS_CTRL, d);
		chk("ctrl cleared", 8'h00, d);
		r = 2'(2 + $urandom % 2);
		reg_wr(`VRC_OFS_CTRL, {2'b00, r, 4'h0}, 1'b1);
		c = {3'b111, 5'($urandom)};
		reg_wr(`VRC_OFS_VSEL, c, 1'b1);
		@(posedge clk);
		#1;
		c1 = code;
		n = 0;
		while (code === c1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		c1 = code;
		repeat (4 << r) @(posedge clk);
		#1;
		chk("slew", {1'b0, c1 + 7'h4}, {1'b0, code});
		repeat (1000) @(posedge clk);
		chk("target", c, {arm, code});
		final_report();
	end
endmodule // vrc_top_bench
